// ---- src/rs159_defs.vh ----
// Constants of the (15,9) GF(16) Reed-Solomon encoder
`ifndef RS159_DEFS_VH
`define RS159_DEFS_VH

// ==========================================================
// Symbol and block geometry
`define RS159_SYM_W 4
`define RS159_MSG_LEN 4'd9
`define RS159_PAR_LEN 4'd6
`define RS159_BLK_LEN 4'd15
`define RS159_FIRST_SLOT 4'd0
`define RS159_LAST_MSG_SLOT 4'd8
`define RS159_FIRST_PAR_SLOT 4'd9
`define RS159_LAST_SLOT 4'd14
`define RS159_STAGES 7
`define RS159_TAPS 6
`define RS159_FB_STAGE 5
`define RS159_OUT_STAGE 6

// ==========================================================
// Field constants, bit 3 holds the constant term
`define RS159_ZERO 4'h0
`define RS159_ONE 4'h8
`define RS159_ALPHA 4'h4
`define RS159_ALPHA4 4'hc
`define RS159_ORDER 5'd15

// ==========================================================
// Generator polynomial tap coefficients
`define RS159_TAP0 4'h3
`define RS159_TAP1 4'h5
`define RS159_TAP2 4'h3
`define RS159_TAP3 4'hc
`define RS159_TAP4 4'h9
`define RS159_TAP5 4'he

// ==========================================================
// Reset values
`define RS159_CNT_RST 4'h0
`define RS159_STAGE_RST 4'h0
`define RS159_READY_RST 1'b1

`endif

// ---- src/rs159_gfmul.v ----
// GF(16) multiplier using exponent lookup and inverse lookup
`timescale 1ns/10ps
`default_nettype none
`include "rs159_defs.vh"

module rs159_gfmul (
  input wire [3:0] a_i,
  input wire [3:0] b_i,
  output reg [3:0] p_o
);

  // ==========================================================
  // Exponent of a nonzero element; zero is handled by the caller
  function [3:0] rs159_log;
    input [3:0] e;
    begin
      case (e)
        4'h1: rs159_log = 4'h3;
        4'h2: rs159_log = 4'h2;
        4'h3: rs159_log = 4'h6;
        4'h4: rs159_log = 4'h1;
        4'h5: rs159_log = 4'h9;
        4'h6: rs159_log = 4'h5;
        4'h7: rs159_log = 4'hb;
        4'h8: rs159_log = 4'h0;
        4'h9: rs159_log = 4'he;
        4'ha: rs159_log = 4'h8;
        4'hb: rs159_log = 4'hd;
        4'hc: rs159_log = 4'h4;
        4'hd: rs159_log = 4'h7;
        4'he: rs159_log = 4'ha;
        4'hf: rs159_log = 4'hc;
        default: rs159_log = 4'h0;
      endcase
    end
  endfunction

  // ==========================================================
  // Element for an exponent 0..14
  function [3:0] rs159_alog;
    input [3:0] x;
    begin
      case (x)
        4'h0: rs159_alog = `RS159_ONE;
        4'h1: rs159_alog = `RS159_ALPHA;
        4'h2: rs159_alog = 4'h2;
        4'h3: rs159_alog = 4'h1;
        4'h4: rs159_alog = `RS159_ALPHA4;
        4'h5: rs159_alog = 4'h6;
        4'h6: rs159_alog = 4'h3;
        4'h7: rs159_alog = 4'hd;
        4'h8: rs159_alog = 4'ha;
        4'h9: rs159_alog = 4'h5;
        4'ha: rs159_alog = 4'he;
        4'hb: rs159_alog = 4'h7;
        4'hc: rs159_alog = 4'hf;
        4'hd: rs159_alog = 4'hb;
        4'he: rs159_alog = 4'h9;
        default: rs159_alog = `RS159_ZERO;
      endcase
    end
  endfunction

  reg [4:0] exp_sum;
  reg [4:0] exp_mod;

  // ==========================================================
  // Product
  always @* begin
    exp_sum = {1'b0, rs159_log(a_i)} + {1'b0, rs159_log(b_i)};
    exp_mod = (exp_sum >= `RS159_ORDER) ? (exp_sum - `RS159_ORDER) : exp_sum;
    if ((a_i == `RS159_ZERO) || (b_i == `RS159_ZERO)) begin
      p_o = `RS159_ZERO;
    end else begin
      p_o = rs159_alog(exp_mod[3:0]);
    end
  end

endmodule // rs159_gfmul
`default_nettype wire

// ---- src/rs159_enc.v ----
// Systematic (15,9) GF(16) Reed-Solomon encoder, top level
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Overview of operation
// - Nine 4-bit message symbols in, fifteen systematic code symbols out.
// - Arithmetic is in GF(16) built from 1 + X + X^4, alpha primitive.
// - Six parity symbols are computed and appended after the message.
// - First nine slots pass each symbol out unchanged and into the generator.
// - Slots ten to fifteen force zero feedback and shift parity out.
// - Symbol bits are polynomial coefficients, leftmost bit the constant term.
// - Field addition is bitwise XOR of the coefficient vectors.
// - Nonzero product is alpha to the exponent sum modulo fifteen, via lookups.
// - Any zero operand gives a zero product.
// - Fixed taps 0011, 0101, 0011, 1100, 1001, 1110 for taps zero to five.
// - All seven stages are zero before a block's first message symbol.
// - Message symbol is output and added to stage five as feedback.
// - Feedback is multiplied by every tap coefficient for the next shift.
// - Shift from old values: five to six, lower plus product upward, zero gets product.
// - In parity slots the register shifts first, then output is taken.
// - Optionally parity is read straight from stages five down to zero.

`include "rs159_defs.vh"

module rs159_enc (
  input wire MCLK_I,
  input wire RESET_N_I,
  input wire SYM_VALID_I,
  input wire BLOCK_START_I,
  input wire [3:0] SYM_DATA_I,
  input wire PAR_DIRECT_I,
  output wire READY_O,
  output wire SYM_VALID_O,
  output wire [3:0] SYM_DATA_O,
  output wire BLOCK_FIRST_O,
  output wire BLOCK_LAST_O,
  output wire PARITY_SLOT_O,
  output wire BLOCK_ABORT_O
);

  // ==========================================================
  // States
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_MSG = 2'b01;
  localparam [1:0] ST_PAR = 2'b10;

  // ==========================================================
  // Decoders used in several places
  function [3:0] rs159_tap;
    input integer idx;
    begin
      case (idx)
        0: rs159_tap = `RS159_TAP0;
        1: rs159_tap = `RS159_TAP1;
        2: rs159_tap = `RS159_TAP2;
        3: rs159_tap = `RS159_TAP3;
        4: rs159_tap = `RS159_TAP4;
        5: rs159_tap = `RS159_TAP5;
        default: rs159_tap = `RS159_ZERO;
      endcase
    end
  endfunction

  // Stage read in direct parity mode: slot 9 reads stage 5, slot 14 stage 0
  function [2:0] rs159_par_idx;
    input [3:0] slot;
    reg [3:0] diff;
    begin
      diff = `RS159_LAST_SLOT - slot;
      rs159_par_idx = diff[2:0];
    end
  endfunction

  function rs159_is_last;
    input [3:0] slot;
    begin
      rs159_is_last = (slot == `RS159_LAST_SLOT);
    end
  endfunction

  // ==========================================================
  // Registers
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [3:0] stage_q [0:`RS159_STAGES-1];
  reg [3:0] stage_d [0:`RS159_STAGES-1];
  reg ready_q;
  reg ready_d;
  reg valid_q;
  reg valid_d;
  reg [3:0] data_q;
  reg [3:0] data_d;
  reg first_q;
  reg first_d;
  reg last_q;
  reg last_d;
  reg parity_q;
  reg parity_d;
  reg abort_q;
  reg abort_d;

  // ==========================================================
  // Combinational helpers
  reg acc;
  reg start_acc;
  reg msg_acc;
  reg par_slot;
  reg shift_en;
  reg [3:0] slot_cur;
  reg [3:0] fb;
  reg [3:0] pre [0:`RS159_STAGES-1];
  wire [3:0] prod [0:`RS159_TAPS-1];
  reg [3:0] par_sym;
  // One loop index per process, so no block wakes another
  integer i_pre;
  integer i_nxt;
  integer i_rst;

  // ==========================================================
  // Slot decode and feedback
  always @* begin
    // In idle only a start is taken; other symbols there are dropped
    acc = SYM_VALID_I & ready_q;
    start_acc = acc & BLOCK_START_I;
    msg_acc = start_acc | (acc & (state_q == ST_MSG));
    par_slot = (state_q == ST_PAR);
    slot_cur = start_acc ? `RS159_FIRST_SLOT : cnt_q;
    // A new start discards any partial block before its first symbol
    for (i_pre = 0; i_pre < `RS159_STAGES; i_pre = i_pre + 1) begin
      pre[i_pre] = start_acc ? `RS159_STAGE_RST : stage_q[i_pre];
    end
    if (msg_acc) begin
      fb = SYM_DATA_I ^ pre[`RS159_FB_STAGE];
    end else begin
      fb = `RS159_ZERO;
    end
    // Direct read-out leaves the register still during parity slots
    shift_en = msg_acc | (par_slot & ~PAR_DIRECT_I);
  end

  // ==========================================================
  // Tap multipliers
  // Taps are constants, so each multiplier folds to plain XOR logic
  genvar g;
  generate
    for (g = 0; g < `RS159_TAPS; g = g + 1) begin : gen_tap
      rs159_gfmul u_mul (
        .a_i(fb),
        .b_i(rs159_tap(g)),
        .p_o(prod[g])
      );
    end
  endgenerate

  // ==========================================================
  // Register next value
  // Shift mode moves every stage; direct mode holds them for read-out
  always @* begin
    for (i_nxt = 0; i_nxt < `RS159_STAGES; i_nxt = i_nxt + 1) begin
      stage_d[i_nxt] = stage_q[i_nxt];
    end
    if (shift_en) begin
      stage_d[`RS159_OUT_STAGE] = pre[`RS159_FB_STAGE];
      for (i_nxt = 1; i_nxt < `RS159_TAPS; i_nxt = i_nxt + 1) begin
        stage_d[i_nxt] = pre[i_nxt-1] ^ prod[i_nxt];
      end
      stage_d[0] = prod[0];
    end else if (start_acc) begin
      for (i_nxt = 0; i_nxt < `RS159_STAGES; i_nxt = i_nxt + 1) begin
        stage_d[i_nxt] = `RS159_STAGE_RST;
      end
    end
  end

  // ==========================================================
  // Sequencing
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (start_acc) begin
          state_d = ST_MSG;
          cnt_d = `RS159_FIRST_SLOT + 4'd1;
        end
      end
      ST_MSG: begin
        if (msg_acc) begin
          cnt_d = slot_cur + 4'd1;
          if (slot_cur == `RS159_LAST_MSG_SLOT) begin
            state_d = ST_PAR;
          end
        end
      end
      ST_PAR: begin
        if (rs159_is_last(cnt_q)) begin
          state_d = ST_IDLE;
          cnt_d = `RS159_CNT_RST;
        end else begin
          cnt_d = cnt_q + 4'd1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = `RS159_CNT_RST;
      end
    endcase
    // Input is refused while parity leaves, so upstream stalls for six slots
    ready_d = (state_d != ST_PAR);
  end

  // ==========================================================
  // Parity read-out, direct mode reads the still register
  // Shift mode takes the top stage after this cycle's shift
  always @* begin
    if (PAR_DIRECT_I) begin
      par_sym = stage_q[rs159_par_idx(cnt_q)];
    end else begin
      par_sym = stage_d[`RS159_OUT_STAGE];
    end
  end

  // ==========================================================
  // Output next value
  always @* begin
    valid_d = msg_acc | par_slot;
    first_d = msg_acc & (slot_cur == `RS159_FIRST_SLOT);
    last_d = par_slot & rs159_is_last(cnt_q);
    parity_d = par_slot;
    abort_d = start_acc & (state_q == ST_MSG) & (cnt_q != `RS159_FIRST_SLOT);
    if (msg_acc) begin
      data_d = SYM_DATA_I;
    end else if (par_slot) begin
      data_d = par_sym;
    end else begin
      data_d = `RS159_ZERO;
    end
  end

  // ==========================================================
  // Flip-flops
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (i_rst = 0; i_rst < `RS159_STAGES; i_rst = i_rst + 1) begin
        stage_q[i_rst] <= `RS159_STAGE_RST;
      end
    end else begin
      for (i_rst = 0; i_rst < `RS159_STAGES; i_rst = i_rst + 1) begin
        stage_q[i_rst] <= stage_d[i_rst];
      end
    end
  end

  // Control, kept apart so each register has a plain reset
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cnt_q <= `RS159_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ready_q <= `RS159_READY_RST;
    end else begin
      ready_q <= ready_d;
    end
  end

  // Output registers, one process each
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      data_q <= `RS159_ZERO;
    end else begin
      data_q <= data_d;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      first_q <= 1'b0;
    end else begin
      first_q <= first_d;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      last_q <= 1'b0;
    end else begin
      last_q <= last_d;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      parity_q <= 1'b0;
    end else begin
      parity_q <= parity_d;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end

  // ==========================================================
  // Ports
  assign READY_O = ready_q;
  assign SYM_VALID_O = valid_q;
  assign SYM_DATA_O = data_q;
  assign BLOCK_FIRST_O = first_q;
  assign BLOCK_LAST_O = last_q;
  assign PARITY_SLOT_O = parity_q;
  assign BLOCK_ABORT_O = abort_q;

endmodule // rs159_enc
`default_nettype wire

// ---- testbench/rs159_enc_sva.sv ----
// Port timing checker of the RS(15,9) encoder
`timescale 1ns/10ps
`default_nettype none
module rs159_enc_sva (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic SYM_VALID_I,
  input wire logic BLOCK_START_I,
  input wire logic [3:0] SYM_DATA_I,
  input wire logic PAR_DIRECT_I,
  input wire logic READY_O,
  input wire logic SYM_VALID_O,
  input wire logic [3:0] SYM_DATA_O,
  input wire logic BLOCK_FIRST_O,
  input wire logic BLOCK_LAST_O,
  input wire logic PARITY_SLOT_O,
  input wire logic BLOCK_ABORT_O
);
  logic [3:0] msg_q;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ==========================================
  // Message symbols out since the block head
  // Restarts on the head so an aborted block is not counted
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) msg_q <= 4'h0;
    else if (SYM_VALID_O && BLOCK_FIRST_O) msg_q <= 4'h1;
    else if (SYM_VALID_O && !PARITY_SLOT_O) msg_q <= msg_q + 4'h1;
  end
  // ==========================================
  // Properties
  head_echo_a: assert property (SYM_VALID_I && READY_O && BLOCK_START_I |=>
    SYM_VALID_O && BLOCK_FIRST_O && SYM_DATA_O == $past(SYM_DATA_I)) else $error("head lost");
  msg_echo_a: assert property (SYM_VALID_O && !PARITY_SLOT_O |->
    SYM_DATA_O == $past(SYM_DATA_I) && $past(SYM_VALID_I && READY_O)) else $error("echo wrong");
  msg_count_a: assert property ($rose(PARITY_SLOT_O) |-> msg_q == 4'h9)
    else $error("message count wrong");
  parity_run_a: assert property ($rose(PARITY_SLOT_O) |->
    (SYM_VALID_O && PARITY_SLOT_O)[*6] ##1 !PARITY_SLOT_O) else $error("parity run wrong");
  last_slot_a: assert property ($rose(PARITY_SLOT_O) |-> ##5 BLOCK_LAST_O)
    else $error("last slot wrong");
  parity_stall_a: assert property ($rose(PARITY_SLOT_O) |-> !READY_O[*5] ##1 READY_O)
    else $error("stall wrong");
  ready_drop_a: assert property ($fell(READY_O) |->
    SYM_VALID_O && !PARITY_SLOT_O ##1 $rose(PARITY_SLOT_O)) else $error("ready drop wrong");
  last_flags_a: assert property (BLOCK_LAST_O |->
    PARITY_SLOT_O && SYM_VALID_O && !BLOCK_FIRST_O) else $error("last flags wrong");
  out_origin_a: assert property (SYM_VALID_O |-> PARITY_SLOT_O || $past(SYM_VALID_I))
    else $error("output without input");
  cover property ($rose(PARITY_SLOT_O));
  cover property (BLOCK_ABORT_O);
  cover property (BLOCK_LAST_O ##1 BLOCK_FIRST_O);
endmodule // rs159_enc_sva
bind rs159_enc rs159_enc_sva chk_i (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
  .SYM_VALID_I(SYM_VALID_I), .BLOCK_START_I(BLOCK_START_I), .SYM_DATA_I(SYM_DATA_I),
  .PAR_DIRECT_I(PAR_DIRECT_I), .READY_O(READY_O), .SYM_VALID_O(SYM_VALID_O),
  .SYM_DATA_O(SYM_DATA_O), .BLOCK_FIRST_O(BLOCK_FIRST_O), .BLOCK_LAST_O(BLOCK_LAST_O),
  .PARITY_SLOT_O(PARITY_SLOT_O), .BLOCK_ABORT_O(BLOCK_ABORT_O));
`default_nettype wire

// ---- testbench/rs159_sink.sv ----
// Downstream sink that gathers each coded block
`timescale 1ns/10ps
`default_nettype none
module rs159_sink (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic vld_i,
  input wire logic first_i,
  input wire logic last_i,
  input wire logic [3:0] data_i,
  output logic [59:0] blk_o,
  output logic [4:0] len_o,
  output logic [7:0] nblk_o
);
  logic [55:0] sh_q;
  logic [4:0] cnt_q;
  // Latched on the last slot, so a following block cannot overwrite it early
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q <= '0;
      cnt_q <= '0;
      blk_o <= '0;
      len_o <= '0;
      nblk_o <= '0;
    end else if (vld_i) begin
      sh_q <= {sh_q[51:0], data_i};
      cnt_q <= first_i ? 5'h1 : cnt_q + 5'h1;
      if (last_i) begin
        blk_o <= {sh_q, data_i};
        len_o <= cnt_q + 5'h1;
        nblk_o <= nblk_o + 8'h1;
      end
    end
  end
endmodule // rs159_sink
`default_nettype wire

// ---- testbench/rs_15_9_gf16_encoder_tb.sv ----
// Self-checking bench of the RS(15,9) encoder
`timescale 1ns/10ps
`default_nettype none
module rs_15_9_gf16_encoder_tb;
  localparam logic [23:0] TAPS = 24'h353c9e;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic start = 1'b0;
  logic [3:0] din = 4'h0;
  logic direct = 1'b0;
  wire rdy, ovld, first, last, par, abrt;
  wire [3:0] dout;
  wire [59:0] blk;
  wire [4:0] len;
  wire [7:0] nblk;
  int n_errors = 0;
  int checks = 0;
  int want = 0;
  int n_abort = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (abrt === 1'b1) n_abort++;
  rs159_enc dut (.MCLK_I(clk), .RESET_N_I(rst_n), .SYM_VALID_I(vld), .BLOCK_START_I(start),
    .SYM_DATA_I(din), .PAR_DIRECT_I(direct), .READY_O(rdy), .SYM_VALID_O(ovld),
    .SYM_DATA_O(dout), .BLOCK_FIRST_O(first), .BLOCK_LAST_O(last), .PARITY_SLOT_O(par),
    .BLOCK_ABORT_O(abrt));
  rs159_sink sink (.clk_i(clk), .rst_n_i(rst_n), .vld_i(ovld), .first_i(first),
    .last_i(last), .data_i(dout), .blk_o(blk), .len_o(len), .nblk_o(nblk));
  // ==========================================
  // Reference arithmetic, bit 3 is the constant term
  function automatic logic [3:0] gm(input logic [3:0] a, input logic [3:0] b);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (b[3-i]) r ^= a;
      a = {1'b0, a[3:1]} ^ (a[0] ? 4'hc : 4'h0);
    end
    return r;
  endfunction
  function automatic logic [23:0] par_of(input logic [35:0] m);
    logic [3:0] s [0:5];
    logic [3:0] f;
    for (int k = 0; k < 6; k++) s[k] = 4'h0;
    for (int i = 0; i < 9; i++) begin
      f = m[35-4*i -: 4] ^ s[5];
      for (int k = 5; k > 0; k--) s[k] = s[k-1] ^ gm(f, TAPS[23-4*k -: 4]);
      s[0] = gm(f, TAPS[23 -: 4]);
    end
    return {s[5], s[4], s[3], s[2], s[1], s[0]};
  endfunction
  // ==========================================
  // Drivers and comparison
  task automatic chk(input string what, input logic [59:0] got, input logic [59:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic s, input logic [3:0] d);
    vld <= 1'b1;
    start <= s;
    din <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
  endtask
  task automatic idle(input int n);
    vld <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic feed(input logic [35:0] m, input logic gap);
    for (int i = 0; i < 9; i++) begin
      put(i == 0, m[35-4*i -: 4]);
      if (gap) idle(1);
    end
  endtask
  task automatic expect_blk(input logic [35:0] m);
    want++;
    for (int k = 0; k < 40 && nblk < want; k++) @(posedge clk);
    chk("block", blk, {m, par_of(m)});
    chk("length", len, 60'd15);
    chk("blocks out", nblk, want);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk("reset outputs", {rdy, ovld, first, last, par, abrt, dout}, 60'h200);
  endtask
  // Second start waits through the parity stall, then follows at once
  task automatic t_back_to_back;
    feed(36'h123456789, 1'b0);
    feed(36'h000000000, 1'b0);
    idle(1);
    expect_blk(36'h123456789);
    expect_blk(36'h000000000);
  endtask
  task automatic t_direct_gaps;
    direct <= 1'b1;
    feed(36'hfedcba980, 1'b1);
    idle(1);
    expect_blk(36'hfedcba980);
    direct <= 1'b0;
  endtask
  task automatic t_idle_drop;
    put(1'b0, 4'h5);
    vld <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      chk("idle drop", ovld, 60'h0);
    end
  endtask
  task automatic t_abort;
    put(1'b1, 4'h1);
    put(1'b0, 4'h2);
    put(1'b0, 4'h3);
    feed(36'h0800c0040, 1'b0);
    idle(1);
    expect_blk(36'h0800c0040);
    chk("abort pulses", n_abort, 60'd1);
  endtask
  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_back_to_back;
    t_direct_gaps;
    t_idle_drop;
    t_abort;
    complete_run;
  end
endmodule // rs_15_9_gf16_encoder_tb
`default_nettype wire
